// ---- hw/mib_counter_readout.sv ----
// Indirect read-out of the per-port and all-port statistics counters
`timescale 1ns/1ps
`include "mib_readout_defines.svh"

module mib_counter_readout #(
    parameter int NUM_PORTS = `NUM_PORTS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input mib_readout_pkg::reg_req_t req,
    output mib_readout_pkg::reg_rsp_t rsp,
    input mib_readout_pkg::count_event_t count_event
);
    import mib_readout_pkg::*;

    localparam int CELLS_PER_PORT = `PER_PORT_COUNTERS + `ALL_PORT_COUNTERS;
    localparam int NUM_CELLS = NUM_PORTS * CELLS_PER_PORT;

    typedef struct packed {
        logic [7:0] table_select;
        logic [7:0] index_trigger;
        logic [`WIDTH_WORD-1:0] word;
        logic is_drop;
        logic is_packet;
        reg_rsp_t rsp;
    } readout_state_t;

    readout_state_t st;
    readout_state_t next_st;

    // ------------------------------------------------------------
    // Trigger decode
    // ------------------------------------------------------------
    logic trig;
    logic trig_ok;
    logic [8:0] trig_idx;
    logic [NUM_CELLS-1:0] cell_hit;
    logic [`WIDTH_VALUE:0] cell_word [NUM_CELLS];
    logic [`WIDTH_VALUE:0] sel_word;

    assign trig = req.wr && req.addr == `OFF_INDEX_TRIGGER;

    // Unknown table or index out of range hits no counter,
    // so a stray trigger can never clear a live count

    always_comb begin
        trig_ok = 1'b0;
        trig_idx = {1'b0, req.wdata};
        if (st.table_select == `TABLE_PER_PORT) begin
            trig_ok = {1'b0, req.wdata} < 9'(NUM_PORTS * `PER_PORT_COUNTERS);
        end else if (st.table_select == `TABLE_ALL_PORT) begin
            trig_idx = `ALL_PORT_BASE + {1'b0, req.wdata};
            trig_ok = {1'b0, req.wdata} < 9'(NUM_PORTS * `ALL_PORT_COUNTERS);
        end
    end

    // ------------------------------------------------------------
    // Counter cells
    // ------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        for (genvar o = 0; o < `PER_PORT_COUNTERS; o++) begin : g_packet
            localparam int ID = p * CELLS_PER_PORT + o;
            localparam logic [8:0] IDX = 9'(p) * `PORT_STRIDE + 9'(o);
            logic [`WIDTH_PACKET-1:0] val;
            logic ovf;
            assign cell_hit[ID] = trig && trig_ok && trig_idx == IDX;
            stat_counter_cell #(.WIDTH(`WIDTH_PACKET)) u_cell (
                .ref_clk(ref_clk),
                .rst(rst),
                .inc(count_event.valid && count_event.index == IDX),
                .amount(count_event.amount),
                .clr(cell_hit[ID]),
                .value(val),
                .ovf(ovf)
            );
            // Reserved bits come back as zero
            assign cell_word[ID] = {ovf, {(`WIDTH_VALUE-`WIDTH_PACKET){1'b0}}, val};
        end
        for (genvar k = 0; k < `ALL_PORT_COUNTERS; k++) begin : g_all
            localparam int ID = p * CELLS_PER_PORT + `PER_PORT_COUNTERS + k;
            localparam int W = (k < 2) ? `WIDTH_BYTES : `WIDTH_DROP;
            localparam logic [8:0] IDX = `ALL_PORT_BASE + 9'(p * `ALL_PORT_COUNTERS + k);
            logic [W-1:0] val;
            logic ovf;
            assign cell_hit[ID] = trig && trig_ok && trig_idx == IDX;
            stat_counter_cell #(.WIDTH(W)) u_cell (
                .ref_clk(ref_clk),
                .rst(rst),
                .inc(count_event.valid && count_event.index == IDX),
                .amount(count_event.amount),
                .clr(cell_hit[ID]),
                .value(val),
                .ovf(ovf)
            );
            if (W < `WIDTH_VALUE) begin : g_pad
                assign cell_word[ID] = {ovf, {(`WIDTH_VALUE-W){1'b0}}, val};
            end else begin : g_full
                assign cell_word[ID] = {ovf, val};
            end
        end
    end

    // One-hot hit, so an OR picks the selected counter
    always_comb begin
        sel_word = '0;
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (cell_hit[i]) begin
                sel_word = sel_word | cell_word[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rsp.rvalid = req.rd;
        next_st.rsp.rdata = `RESET_BYTE;
        if (req.wr && req.addr == `OFF_TABLE_SELECT) begin
            next_st.table_select = req.wdata;
        end
        if (trig) begin
            next_st.index_trigger = req.wdata;
            // Captured word stays put until the next trigger
            next_st.word = `RESET_WORD;
            next_st.word[`BIT_OVERFLOW] = sel_word[`WIDTH_VALUE];
            next_st.word[`BIT_VALID] = trig_ok;
            next_st.word[`WIDTH_VALUE-1:0] = sel_word[`WIDTH_VALUE-1:0];
            next_st.is_drop = trig_ok && st.table_select == `TABLE_ALL_PORT && req.wdata[`ALL_PORT_DROP_BIT];
            next_st.is_packet = trig_ok && st.table_select == `TABLE_PER_PORT;
        end
        if (req.rd) begin
            unique case (req.addr)
                `OFF_TABLE_SELECT: next_st.rsp.rdata = st.table_select;
                `OFF_INDEX_TRIGGER: next_st.rsp.rdata = st.index_trigger;
                `OFF_DATA_BYTE4: next_st.rsp.rdata = st.word[`FIELD_BYTE4];
                `OFF_DATA_BYTE3: next_st.rsp.rdata = st.word[`FIELD_BYTE3];
                `OFF_DATA_BYTE2: next_st.rsp.rdata = st.word[`FIELD_BYTE2];
                `OFF_DATA_BYTE1: next_st.rsp.rdata = st.word[`FIELD_BYTE1];
                `OFF_DATA_BYTE0: next_st.rsp.rdata = st.word[`FIELD_BYTE0];
                default: next_st.rsp.rdata = `RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rsp = st.rsp;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_trigger_valid: assert property (@(posedge ref_clk) disable iff (rst)
        trig |=> st.word[`BIT_VALID] == $past(trig_ok))
        else $error("valid bit does not follow trigger decode");
    a_word_stable: assert property (@(posedge ref_clk) disable iff (rst)
        !trig |=> $stable(st.word))
        else $error("data word changed without trigger");
    a_byte_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        st.word[`BIT_WORD_TOP] == 1'b0 && st.word[`BIT_RESERVED] == 1'b0)
        else $error("reserved word bits not zero");
    a_drop_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        st.is_drop |-> st.word[`BIT_RESERVED:`WIDTH_DROP] == '0)
        else $error("drop counter reserved bits not zero");
    a_packet_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        st.is_packet |-> st.word[`BIT_RESERVED:`WIDTH_PACKET] == '0)
        else $error("packet counter reserved bits not zero");
    a_invalid_empty: assert property (@(posedge ref_clk) disable iff (rst)
        (trig && !trig_ok) |=> st.word == `RESET_WORD)
        else $error("invalid index left data in word");
    a_top_byte_read: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && !req.wr && req.addr == `OFF_DATA_BYTE4) |=> rsp.rvalid && rsp.rdata == st.word[`FIELD_BYTE4])
        else $error("top data byte read wrong");
    a_low_byte_read: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && !req.wr && req.addr == `OFF_DATA_BYTE0) |=> rsp.rdata == st.word[`FIELD_BYTE0])
        else $error("low data byte read wrong");
    a_single_hit: assert property (@(posedge ref_clk) disable iff (rst)
        trig && trig_ok |-> $onehot(cell_hit))
        else $error("trigger must clear exactly one counter");

    // ------------------------------------------------------------
    // Read-out checks
    // ------------------------------------------------------------
    // Host sees each answer exactly one cycle after asking
    a_read_answers: assert property (@(posedge ref_clk) disable iff (rst)
        req.rd |=> rsp.rvalid)
        else $error("read strobe got no answer");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        !req.rd |=> !rsp.rvalid && rsp.rdata == `RESET_BYTE)
        else $error("answer without a read strobe");
    a_table_readback: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && !req.wr && req.addr == `OFF_TABLE_SELECT) |=> rsp.rdata == st.table_select)
        else $error("table select read back wrong");
    a_index_readback: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && !req.wr && req.addr == `OFF_INDEX_TRIGGER) |=> rsp.rdata == st.index_trigger)
        else $error("index register read back wrong");
    a_bad_index_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (trig && !trig_ok) |-> cell_hit == '0)
        else $error("rejected trigger cleared a counter");
    a_capture_value: assert property (@(posedge ref_clk) disable iff (rst)
        (trig && trig_ok) |=> st.word[`WIDTH_VALUE-1:0] == $past(sel_word[`WIDTH_VALUE-1:0]))
        else $error("captured value differs from counter");
    a_overflow_copy: assert property (@(posedge ref_clk) disable iff (rst)
        (trig && trig_ok) |=> st.word[`BIT_OVERFLOW] == $past(sel_word[`WIDTH_VALUE]))
        else $error("overflow bit not captured");
endmodule

// ---- hw/mib_readout_defines.svh ----
// Offsets, encodings and field positions of the statistics read-out block
`ifndef MIB_READOUT_DEFINES_SVH
`define MIB_READOUT_DEFINES_SVH

`define OFF_TABLE_SELECT 8'h6E
`define OFF_INDEX_TRIGGER 8'h6F
`define OFF_DATA_BYTE4 8'h74
`define OFF_DATA_BYTE3 8'h75
`define OFF_DATA_BYTE2 8'h76
`define OFF_DATA_BYTE1 8'h77
`define OFF_DATA_BYTE0 8'h78

`define TABLE_PER_PORT 8'h1C
`define TABLE_ALL_PORT 8'h1D

`define NUM_PORTS 5
`define PER_PORT_COUNTERS 32
`define ALL_PORT_COUNTERS 4
`define PORT_STRIDE 9'h020
`define ALL_PORT_BASE 9'h100

`define WIDTH_PACKET 30
`define WIDTH_BYTES 36
`define WIDTH_DROP 16
`define WIDTH_VALUE 36
`define WIDTH_AMOUNT 16

`define BIT_OVERFLOW 38
`define BIT_VALID 37
`define BIT_RESERVED 36
`define BIT_WORD_TOP 39
`define WIDTH_WORD 40
`define FIELD_BYTE4 39:32
`define FIELD_BYTE3 31:24
`define FIELD_BYTE2 23:16
`define FIELD_BYTE1 15:8
`define FIELD_BYTE0 7:0
`define ALL_PORT_DROP_BIT 1

`define RESET_BYTE 8'h00
`define RESET_WORD 40'h00_0000_0000

`endif

// ---- hw/mib_readout_pkg.sv ----
// Carrier types of the statistics read-out block
package mib_readout_pkg;

    // Register access from the serial front end, same clock
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
    } reg_rsp_t;

    // One counting event; index uses the read-out index space
    typedef struct packed {
        logic valid;
        logic [8:0] index;
        logic [15:0] amount;
    } count_event_t;

endpackage

// ---- hw/stat_counter_cell.sv ----
// One statistics counter with overflow flag and clear-on-read
`timescale 1ns/1ps
`include "mib_readout_defines.svh"

module stat_counter_cell #(
    parameter int WIDTH = `WIDTH_PACKET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic inc,
    input wire logic [`WIDTH_AMOUNT-1:0] amount,
    input wire logic clr,
    output logic [WIDTH-1:0] value,
    output logic ovf
);
    import mib_readout_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic ovf;
    } cell_state_t;

    cell_state_t st;
    cell_state_t next_st;
    logic [WIDTH:0] sum;

    always_comb begin
        sum = {1'b0, st.count} + {{(WIDTH+1-`WIDTH_AMOUNT){1'b0}}, amount};
        next_st = st;
        if (clr) begin
            // Event in the clearing cycle starts the new count
            next_st.count = inc ? sum[WIDTH-1:0] - st.count : '0;
            next_st.ovf = 1'b0;
        end else if (inc) begin
            next_st.count = sum[WIDTH-1:0];
            if (sum[WIDTH]) begin
                next_st.ovf = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign value = st.count;
    assign ovf = st.ovf;

    a_clear_zeroes: assert property (@(posedge ref_clk) disable iff (rst) clr |=> ovf == 1'b0)
        else $error("counter overflow not cleared by read");
    a_clear_keeps_event: assert property (@(posedge ref_clk) disable iff (rst)
        clr |=> value == (WIDTH'($past(inc)) * WIDTH'($past(amount))))
        else $error("counter value after clear wrong");
    a_count_adds: assert property (@(posedge ref_clk) disable iff (rst)
        (inc && !clr) |=> value == WIDTH'($past(value) + WIDTH'($past(amount))))
        else $error("counter did not add amount");
    a_overflow_sets: assert property (@(posedge ref_clk) disable iff (rst)
        (inc && !clr && sum[WIDTH]) |=> ovf)
        else $error("overflow flag not set on wrap");
endmodule

// ---- testbench/host_model.sv ----
// Host-side register access model for the statistics read-out block
`timescale 1ns/1ps

module host_model (
    input wire logic ref_clk,
    output mib_readout_pkg::reg_req_t req,
    input wire mib_readout_pkg::reg_rsp_t rsp
);
    import mib_readout_pkg::*;

    initial req = '0;

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    // One strobe per access, dropped at the taking edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask

    // Bounded wait for the answer; ok low means it never came
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 4 && !ok; n++) begin
            #1;
            if (rsp.rvalid === 1'b1) begin
                ok = 1'b1;
                d = rsp.rdata;
            end else begin
                @(posedge ref_clk);
            end
        end
    endtask
endmodule

// ---- testbench/mib_counter_indirect_readout_bench.sv ----
// Self-checking bench of the statistics read-out block
`timescale 1ns/1ps
`include "mib_readout_defines.svh"

module mib_counter_indirect_readout_bench;
    import mib_readout_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req;
    reg_rsp_t rsp;
    count_event_t count_event = '0;
    int mismatches = 0;
    int comparisons = 0;
    int seed = 32'h92708152;
    logic [36:0] exp_cnt [0:511];
    logic exp_ovf [0:511];
    logic [8:0] pick [0:4] = '{9'h00D, 9'h02D, 9'h09F, 9'h103, 9'h110};

    always #10 ref_clk = ~ref_clk;

    mib_counter_readout #(.NUM_PORTS(5)) DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp),
        .count_event(count_event));
    host_model host (.ref_clk(ref_clk), .req(req), .rsp(rsp));

    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function automatic int width_of(input logic [8:0] idx);
        if (idx >= 9'h100) return idx[1] ? 16 : 36;
        return 30;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // Wrap, not saturate, so overflow is the sticky carry
    task automatic bump(input logic [8:0] idx, input logic [15:0] amt);
        logic [37:0] sum;
        sum = exp_cnt[idx] + amt;
        if ((sum >> width_of(idx)) != 0) exp_ovf[idx] = 1'b1;
        exp_cnt[idx] = 37'(sum & ((38'h1 << width_of(idx)) - 1));
        @(posedge ref_clk);
        count_event <= '{valid: 1'b1, index: idx, amount: amt};
        @(posedge ref_clk);
        count_event <= '0;
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        logic ok;
        host.read_reg(a, d, ok);
        if (!ok) begin
            mismatches++;
            $display("ERROR t=%0t no read answer", $time);
            print_verdict();
        end
    endtask

    // Bytes fetched lowest first, to show the word holds meanwhile
    task automatic fetch_word(output logic [39:0] w);
        logic [7:0] b;
        for (int k = 0; k < 5; k++) begin
            rd8(8'(`OFF_DATA_BYTE0 - k), b);
            w[8*k +: 8] = b;
        end
    endtask

    task automatic read_counter(input logic [7:0] tbl, input logic [7:0] ix);
        logic [39:0] w;
        logic [8:0] idx;
        logic good;
        good = (tbl == `TABLE_PER_PORT && ix < 8'hA0) || (tbl == `TABLE_ALL_PORT && ix < 8'h14);
        idx = {tbl == `TABLE_ALL_PORT, ix};
        host.write_reg(`OFF_TABLE_SELECT, tbl);
        host.write_reg(`OFF_INDEX_TRIGGER, ix);
        fetch_word(w);
        check(w, good ? {1'b0, exp_ovf[idx], 1'b1, exp_cnt[idx]} : 40'h0, "counter word");
        if (good) begin
            exp_cnt[idx] = '0;
            exp_ovf[idx] = 1'b0;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] b;
        logic [7:0] b1;
        logic [7:0] b0;
        logic [39:0] w;
        for (int i = 0; i < 512; i++) begin
            exp_cnt[i] = '0;
            exp_ovf[i] = 1'b0;
        end
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        host.write_reg(`OFF_TABLE_SELECT, `TABLE_ALL_PORT);
        rd8(`OFF_TABLE_SELECT, b);
        check(40'(b), 40'h1D, "table readback");
        host.write_reg(`OFF_INDEX_TRIGGER, 8'h05);
        rd8(`OFF_INDEX_TRIGGER, b);
        check(40'(b), 40'h05, "index readback");
        host.write_reg(`OFF_DATA_BYTE4, 8'hFF);
        rd8(`OFF_DATA_BYTE4, b);
        check(40'(b), 40'h20, "read-only top byte");
        rd8(8'h70, b);
        check(40'(b), 40'h00, "unmapped read");
        $display("test registers done");
        // Every counted index except the 16-bit drop counter 9'h103 is read back long before it could wrap
        for (int n = 0; n < 40; n++) bump(pick[$unsigned($random(seed)) % 5], 16'($random(seed)));
        read_counter(`TABLE_PER_PORT, 8'h0D);
        read_counter(`TABLE_PER_PORT, 8'h2D);
        read_counter(`TABLE_PER_PORT, 8'h9F);
        read_counter(`TABLE_ALL_PORT, 8'h03);
        read_counter(`TABLE_ALL_PORT, 8'h10);
        read_counter(`TABLE_PER_PORT, 8'h2D);
        $display("test random counts done");
        bump(9'h102, 16'hFFFF);
        bump(9'h102, 16'h0003);
        read_counter(`TABLE_ALL_PORT, 8'h02);
        read_counter(`TABLE_ALL_PORT, 8'h02);
        read_counter(`TABLE_ALL_PORT, 8'h12);
        $display("test overflow done");
        bump(9'h013, 16'h0007);
        read_counter(`TABLE_PER_PORT, 8'hA0);
        read_counter(`TABLE_ALL_PORT, 8'h14);
        read_counter(8'h1E, 8'h13);
        read_counter(`TABLE_PER_PORT, 8'h13);
        $display("test invalid index done");
        // Drop counter: flag byte and the two value bytes only
        bump(9'h103, 16'h0021);
        host.write_reg(`OFF_TABLE_SELECT, `TABLE_ALL_PORT);
        host.write_reg(`OFF_INDEX_TRIGGER, 8'h03);
        rd8(`OFF_DATA_BYTE4, b);
        rd8(`OFF_DATA_BYTE1, b1);
        rd8(`OFF_DATA_BYTE0, b0);
        check(40'({b, b1, b0}), 40'({1'b0, exp_ovf[9'h103], 1'b1, 5'h00, exp_cnt[9'h103][15:0]}), "drop bytes");
        exp_cnt[9'h103] = '0;
        exp_ovf[9'h103] = 1'b0;
        // Event lands in the very cycle the counter is read
        bump(9'h013, 16'h0005);
        host.write_reg(`OFF_TABLE_SELECT, `TABLE_PER_PORT);
        fork
            host.write_reg(`OFF_INDEX_TRIGGER, 8'h13);
            bump(9'h013, 16'h0009);
        join
        fetch_word(w);
        check(w, 40'h20_0000_0005, "old value on racing read");
        exp_cnt[9'h013] = 37'h9;
        read_counter(`TABLE_PER_PORT, 8'h13);
        $display("test partial and racing reads done");
        // Mid-run reset wipes counters and registers
        bump(9'h00D, 16'h0003);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        exp_cnt[9'h00D] = '0;
        rd8(`OFF_TABLE_SELECT, b);
        check(40'(b), 40'h00, "table after reset");
        read_counter(`TABLE_PER_PORT, 8'h0D);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
